// ---- common/bfu_branch_target_instruction_cache_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Lookup and allocate port between core and target cache memory
interface bfu_branch_target_instruction_cache_if;
    import bfu_pkg::*;
    localparam int IDX_W = $clog2(BRANCH_TARGET_INSTRUCTION_CACHE_ENTRIES);
    logic              rd_en;     // Lookup strobe
    logic [IDX_W-1:0]  rd_idx;    // Lookup index
    logic              rd_valid;  // Registered entry valid
    logic [ADDR_W-1:0] rd_tag;    // Registered entry tag
    logic              wr_en;     // Allocate strobe
    logic [IDX_W-1:0]  wr_idx;    // Allocate index
    logic [ADDR_W-1:0] wr_tag;    // Allocate tag
    modport core (output rd_en, rd_idx, wr_en, wr_idx, wr_tag,
                  input rd_valid, rd_tag);
    modport mem (input rd_en, rd_idx, wr_en, wr_idx, wr_tag,
                 output rd_valid, rd_tag);
endinterface
`default_nettype wire

// ---- common/bfu_pkg.sv ----
// Shared constants and types of the branch and fetch front end
package bfu_pkg;
    localparam int ADDR_W         = 32;  // Instruction address width
    localparam int WORD_BYTES     = 4;   // Bytes per instruction
    localparam int GROUP_MAX      = 4;   // Instructions per fetch group
    localparam int BLOCK_BYTES    = 32;  // Cache block size in bytes
    localparam int MAX_UNRESOLVED = 3;   // Unresolved predicted branches
    localparam int RAS_DEPTH      = 4;   // Return-address stack entries
    localparam int BRANCH_TARGET_INSTRUCTION_CACHE_ENTRIES   = 16;  // Target cache entries
    localparam logic [31:0] RESET_PC = 32'h0000_0100;  // First fetch

    // Branch kinds seen by the branch unit
    typedef enum logic [2:0] {
        BR_UNCOND,    // Unconditional direct
        BR_COND,      // Conditional direct
        BR_LINK,      // Conditional to link register
        BR_COUNT,     // Conditional to count register
        BR_CNT_COND   // Counter decrement plus condition
    } bfu_kind_t;
endpackage

// ---- rtl/bfu_branch_target_instruction_cache_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
// Target cache tag store with registered read data
module bfu_branch_target_instruction_cache_mem
    import bfu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Core side
    bfu_branch_target_instruction_cache_if.mem  bt
);
    logic [BRANCH_TARGET_INSTRUCTION_CACHE_ENTRIES-1:0] vld;                  // Entry valid bits
    logic [ADDR_W-1:0]       tags [BRANCH_TARGET_INSTRUCTION_CACHE_ENTRIES];  // Branch address tags

    // Valid bits cleared by reset, set on allocation
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vld <= '0;
        end else if (bt.wr_en) begin
            vld[bt.wr_idx] <= 1'b1;
        end
    end

    // Tag array, no reset needed behind the valid bits
    always_ff @(posedge clk_sys) begin
        if (bt.wr_en) begin
            tags[bt.wr_idx] <= bt.wr_tag;
        end
    end

    // Read data held in a register until the next lookup
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bt.rd_valid <= 1'b0;
            bt.rd_tag   <= '0;
        end else if (bt.rd_en) begin
            bt.rd_valid <= vld[bt.rd_idx];
            bt.rd_tag   <= tags[bt.rd_idx];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/bfu_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module bfu_core
    import bfu_pkg::*;
#(
    parameter int MAX_UNR = MAX_UNRESOLVED,  // Unresolved branch limit
    parameter int RAS_N   = RAS_DEPTH        // Return stack depth
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Branch execute request from the queue
    input  wire logic              br_valid,
    input  wire bfu_kind_t         br_kind,
    input  wire logic [ADDR_W-1:0] br_pc,
    input  wire logic [ADDR_W-1:0] br_target,
    input  wire logic              br_pred_taken,
    input  wire logic              br_sets_link,
    // Status for the oldest unresolved branch
    input  wire logic              cond_known,
    input  wire logic              cond_taken,
    input  wire logic              link_ready,
    input  wire logic [ADDR_W-1:0] link_value,
    input  wire logic              count_ready,
    input  wire logic [ADDR_W-1:0] count_value,
    input  wire logic              count_zero,
    // Instruction cache access
    output wire logic              ic_req,
    output wire logic [ADDR_W-1:0] ic_addr,
    output wire logic [2:0]        ic_cnt,
    // Fetch group into the instruction queue
    output wire logic              grp_valid,
    output wire logic [ADDR_W-1:0] grp_addr,
    output wire logic [2:0]        grp_cnt,
    output wire logic              grp_branch_target_instruction_cache,
    // Branch outcome
    output wire logic              br_done,
    output wire logic              br_fold,
    output wire logic              flush,
    output wire logic [1:0]        unresolved
);
    localparam int OFF_W  = $clog2(BLOCK_BYTES);
    localparam int WSH    = $clog2(WORD_BYTES);
    localparam int RAS_PW = $clog2(RAS_N);
    localparam int UC_W   = 2;
    localparam int IDX_W  = $clog2(BRANCH_TARGET_INSTRUCTION_CACHE_ENTRIES);
    localparam logic [ADDR_W-1:0] WORD_STEP = ADDR_W'(WORD_BYTES);

    // Whole state of the unit
    typedef struct packed {
        logic [ADDR_W-1:0]                 fpc;       // Next sequential
        logic                              ic_req;    // Access issued
        logic [ADDR_W-1:0]                 ic_addr;
        logic [2:0]                        ic_cnt;
        logic                              redir;     // Redirect pending
        logic                              branch_target_instruction_cache_try;  // Taken direct branch, lookup used
        logic [ADDR_W-1:0]                 redir_pc;
        logic [ADDR_W-1:0]                 br_pc;     // Last branch
        logic                              grp_valid;
        logic [ADDR_W-1:0]                 grp_addr;
        logic [2:0]                        grp_cnt;
        logic                              grp_branch_target_instruction_cache;
        logic                              br_done;
        logic                              br_fold;
        logic                              flush;
        logic [RAS_N-1:0][ADDR_W-1:0]      ras;       // Return stack
        logic [RAS_PW-1:0]                 rtop;      // Next free slot
        logic [UC_W-1:0]                   ucnt;      // Unresolved count
        logic [MAX_UNR-1:0][2:0]           ekind;     // Oldest first
        logic [MAX_UNR-1:0]                etaken;
        logic [MAX_UNR-1:0][ADDR_W-1:0]    etarget;
        logic [MAX_UNR-1:0][ADDR_W-1:0]    efall;
    } bfu_state_t;

    bfu_state_t        s;            // Registered state
    bfu_state_t        n;            // Next state
    bfu_kind_t         okind;        // Kind of oldest unresolved
    logic              rslv_ready;   // Oldest can resolve now
    logic              rslv_taken;   // Its real direction
    logic [ADDR_W-1:0] rslv_target;  // Its real target
    logic              mis_now;      // Oldest found mispredicted
    logic [ADDR_W-1:0] correct_pc;   // Restart address
    logic              exec_now;     // Branch executes this cycle
    logic              take_now;     // Executed branch predicted taken
    logic [ADDR_W-1:0] ras_top;      // Top of return stack
    logic [ADDR_W-1:0] pred_target;  // Predicted target
    logic              branch_target_instruction_cache_hit;     // Lookup matched
    logic [ADDR_W-1:0] issue;        // Address of this cycle's access

    bfu_branch_target_instruction_cache_if bt();

    // Words left before the block end, capped at one group
    function automatic logic [2:0] grp_len(input logic [ADDR_W-1:0] a);
        logic [OFF_W:0] left;
        left = (OFF_W+1)'(BLOCK_BYTES) - {1'b0, a[OFF_W-1:0]};
        left = left >> WSH;
        if (left > (OFF_W+1)'(GROUP_MAX)) begin
            grp_len = 3'(GROUP_MAX);
        end else begin
            grp_len = left[2:0];
        end
    endfunction

    // Address that follows a group
    function automatic logic [ADDR_W-1:0] after(input logic [ADDR_W-1:0] a);
        after = a + (ADDR_W'(grp_len(a)) << WSH);
    endfunction

    // Target cache tag store
    bfu_branch_target_instruction_cache_mem u_mem (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bt      (bt.mem)
    );

    // Resolution readiness of the oldest branch
    assign okind = bfu_kind_t'(s.ekind[0]);
    assign rslv_ready = (s.ucnt != '0) && (
        (okind == BR_COND)  ? cond_known :
        (okind == BR_LINK)  ? (link_ready && cond_known) :
        (okind == BR_COUNT) ? (count_ready && cond_known) :
        ((count_ready && (count_zero || cond_known))
         || (cond_known && !cond_taken)));
    assign rslv_taken = (okind == BR_CNT_COND)
        ? (cond_known && cond_taken && count_ready && !count_zero)
        : cond_taken;
    assign rslv_target = (okind == BR_LINK)  ? link_value :
                         (okind == BR_COUNT) ? count_value : s.etarget[0];
    assign mis_now = rslv_ready && ((rslv_taken != s.etaken[0]) ||
                     (rslv_taken && (rslv_target != s.etarget[0])));
    assign correct_pc = rslv_taken ? rslv_target : s.efall[0];

    // Execute gate; conditionals stop at the unresolved limit
    assign exec_now = br_valid && !s.br_done && !s.redir && !mis_now &&
                      ((br_kind == BR_UNCOND) ||
                       (s.ucnt < UC_W'(MAX_UNR)));
    assign take_now = exec_now && ((br_kind == BR_UNCOND) || br_pred_taken);
    assign ras_top = s.ras[s.rtop - RAS_PW'(1)];
    assign pred_target = (br_kind == BR_LINK) ? ras_top : br_target;

    // Lookup on execute, allocate on a direct miss
    assign branch_target_instruction_cache_hit  = bt.rd_valid && (bt.rd_tag == s.br_pc);
    assign bt.rd_en  = exec_now;
    assign bt.rd_idx = br_pc[IDX_W+WSH-1:WSH];
    assign bt.wr_en  = s.redir && s.branch_target_instruction_cache_try && !branch_target_instruction_cache_hit;
    assign bt.wr_idx = s.br_pc[IDX_W+WSH-1:WSH];
    assign bt.wr_tag = s.br_pc;

    // Next-state logic
    always_comb begin
        n = s;
        n.grp_valid = 1'b0;
        n.br_done   = 1'b0;
        n.br_fold   = 1'b0;
        n.flush     = 1'b0;
        n.redir     = 1'b0;
        n.branch_target_instruction_cache_try  = 1'b0;
        issue       = s.fpc;
        // Cache delivers one cycle after its access
        if (s.ic_req) begin
            n.grp_valid = 1'b1;
            n.grp_addr  = s.ic_addr;
            n.grp_cnt   = s.ic_cnt;
            n.grp_branch_target_instruction_cache  = 1'b0;
        end
        // Redirect: target cache group, else cache access at target
        if (s.redir) begin
            issue = s.redir_pc;
            if (s.branch_target_instruction_cache_try && branch_target_instruction_cache_hit) begin
                n.grp_valid = 1'b1;
                n.grp_addr  = s.redir_pc;
                n.grp_cnt   = grp_len(s.redir_pc);
                n.grp_branch_target_instruction_cache  = 1'b1;
                issue       = after(s.redir_pc);
            end
        end
        // One access per cycle, cut at the block end
        n.ic_req  = 1'b1;
        n.ic_addr = issue;
        n.ic_cnt  = grp_len(issue);
        n.fpc     = after(issue);
        // Resolve oldest: restart or retire it
        if (rslv_ready) begin
            if (mis_now) begin
                n.flush     = 1'b1;
                n.ucnt      = '0;
                n.grp_valid = 1'b0;
                n.ic_req    = 1'b0;
                n.redir     = 1'b1;
                n.redir_pc  = correct_pc;
            end else begin
                for (int i = 0; i < MAX_UNR - 1; i++) begin
                    n.ekind[i]   = s.ekind[i+1];
                    n.etaken[i]  = s.etaken[i+1];
                    n.etarget[i] = s.etarget[i+1];
                    n.efall[i]   = s.efall[i+1];
                end
                n.ucnt = s.ucnt - UC_W'(1);
            end
        end
        // Execute a branch
        if (exec_now) begin
            n.br_done = 1'b1;
            n.br_pc   = br_pc;
            if (br_kind == BR_LINK) begin
                n.rtop = s.rtop - RAS_PW'(1);
            end
            if (br_sets_link) begin
                n.ras[n.rtop] = br_pc + WORD_STEP;
                n.rtop        = n.rtop + RAS_PW'(1);
            end
            // Predicted branches wait in order for resolution
            if (br_kind != BR_UNCOND) begin
                n.ekind[n.ucnt]   = br_kind;
                n.etaken[n.ucnt]  = take_now;
                n.etarget[n.ucnt] = pred_target;
                n.efall[n.ucnt]   = br_pc + WORD_STEP;
                n.ucnt            = n.ucnt + UC_W'(1);
            end
            // Taken: drop fall-through, redirect next cycle
            if (take_now) begin
                n.grp_valid = 1'b0;
                n.ic_req    = 1'b0;
                n.redir     = 1'b1;
                n.redir_pc  = pred_target;
                n.branch_target_instruction_cache_try  = (br_kind == BR_UNCOND) ||
                              (br_kind == BR_COND);
                n.br_fold   = !br_sets_link &&
                              (br_kind != BR_CNT_COND);
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s     <= '0;
            s.fpc <= RESET_PC;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state
    assign ic_req     = s.ic_req;
    assign ic_addr    = s.ic_addr;
    assign ic_cnt     = s.ic_cnt;
    assign grp_valid  = s.grp_valid;
    assign grp_addr   = s.grp_addr;
    assign grp_cnt    = s.grp_cnt;
    assign grp_branch_target_instruction_cache   = s.grp_branch_target_instruction_cache;
    assign br_done    = s.br_done;
    assign br_fold    = s.br_fold;
    assign flush      = s.flush;
    assign unresolved = s.ucnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Steps of a taken branch
    sequence s_branch_target_instruction_cache_taken;
        s.redir && s.branch_target_instruction_cache_try && branch_target_instruction_cache_hit && !mis_now;
    endsequence
    sequence s_ind_taken;
        (s.br_done && s.redir && !s.branch_target_instruction_cache_try && !mis_now) ##1 !mis_now;
    endsequence

    link_wait_a: assert property (rslv_ready && okind == BR_LINK |-> link_ready)
        else $error("link branch resolved without link value");
    count_wait_a: assert property (rslv_ready && okind == BR_COUNT |-> count_ready)
        else $error("count branch resolved without count value");
    dec_cond_wait_a: assert property (rslv_ready && okind == BR_CNT_COND |-> count_ready || (cond_known && !cond_taken))
        else $error("decrement branch resolved too early");
    unres_limit_a: assert property (s.ucnt == UC_W'(MAX_UNR) && br_valid && br_kind != BR_UNCOND && !s.br_done |=> !br_done)
        else $error("fourth conditional branch executed");
    branch_target_instruction_cache_group_a: assert property (s_branch_target_instruction_cache_taken |=> grp_valid && grp_branch_target_instruction_cache && grp_addr == $past(s.redir_pc))
        else $error("target cache group late or wrong");
    block_span_a: assert property (grp_valid |-> grp_cnt != 3'h0 && int'(grp_addr[OFF_W-1:0]) + int'(grp_cnt) * WORD_BYTES <= BLOCK_BYTES)
        else $error("fetch group crosses a block");
    branch_target_instruction_cache_tail_a: assert property (grp_valid && grp_branch_target_instruction_cache && !exec_now && !mis_now |=> grp_valid && !grp_branch_target_instruction_cache && grp_addr == $past(grp_addr) + ($past(ADDR_W'(grp_cnt)) << WSH))
        else $error("cache tail not one cycle after");
    branch_target_instruction_cache_direct_a: assert property (exec_now && (br_kind == BR_LINK || br_kind == BR_COUNT) |=> !s.branch_target_instruction_cache_try ##1 !bt.wr_en)
        else $error("indirect branch used target cache");
    ind_bubble_a: assert property (s_ind_taken |=> grp_valid && !grp_branch_target_instruction_cache && grp_addr == $past(s.redir_pc, 2))
        else $error("indirect target not two cycles after");
    no_bubble_a: assert property (exec_now && !take_now && s.ic_req |=> grp_valid && grp_addr == $past(s.ic_addr))
        else $error("not-taken branch made a bubble");
    fold_a: assert property (take_now && !br_sets_link && br_kind != BR_CNT_COND |=> br_fold && br_done)
        else $error("taken plain branch not folded");
    restart_a: assert property (mis_now |=> flush && !grp_valid ##1 s.ic_req && s.ic_addr == $past(correct_pc, 2))
        else $error("fetch did not restart at target");
    ras_pop_a: assert property (take_now && br_kind == BR_LINK |=> s.redir_pc == $past(ras_top))
        else $error("link prediction not from stack top");
endmodule
`default_nettype wire

// ---- sim/bfu_far_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Far side: answers status of the oldest open branch after a delay
module bfu_far_model
    import bfu_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Open branch count from the core
    input  wire logic [1:0]        unresolved,
    // Bench controls: which values to give, delay, outcome
    input  wire logic [2:0]        give,
    input  wire logic [3:0]        lat,
    input  wire logic              want_taken,
    input  wire logic [ADDR_W-1:0] tval,
    // Status toward the core
    output var logic               cond_known,
    output var logic               cond_taken,
    output var logic               link_ready,
    output var logic [ADDR_W-1:0]  link_value,
    output var logic               count_ready,
    output var logic [ADDR_W-1:0]  count_value,
    output var logic               count_zero
);
    logic [3:0] wait_cnt;  // Cycles a branch has waited
    logic       ready;     // Delay has run out
    assign ready = (unresolved != 2'h0) && (wait_cnt >= lat);
    // Delay counter, restarts when nothing is open
    always_ff @(negedge clk_sys or posedge rst) begin
        if (rst) wait_cnt <= 4'h0;
        else if (unresolved == 2'h0) wait_cnt <= 4'h0;
        else if (wait_cnt < lat) wait_cnt <= wait_cnt + 4'h1;
    end
    // Status lines; withheld values are scrambled, never left stale
    always_ff @(negedge clk_sys or posedge rst) begin
        if (rst) begin
            {cond_known, cond_taken, link_ready, count_ready} <= 4'h0;
            {link_value, count_value} <= 64'h0;
            count_zero <= 1'b0;
        end else begin
            cond_known  <= ready & give[0];
            link_ready  <= ready & give[1];
            count_ready <= ready & give[2];
            cond_taken  <= ready ? want_taken : ~cond_taken;
            link_value  <= (ready & give[1]) ? tval : ~link_value;
            count_value <= (ready & give[2]) ? tval : ~count_value;
            count_zero  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the branch and fetch front end
module tb_top
    import bfu_pkg::*;
;
    logic clk_sys = 1'b0;      // Core clock
    logic rst;                 // Async reset
    logic br_valid, br_pred_taken, br_sets_link;
    bfu_kind_t br_kind;        // Branch request kind
    logic [31:0] br_pc, br_target, fix_pc, exp_pc, tval, r;
    logic cond_known, cond_taken, link_ready, count_ready, count_zero;
    logic [31:0] link_value, count_value, ic_addr, grp_addr;
    logic ic_req, grp_valid, grp_branch_target_instruction_cache, br_done, br_fold, flush;
    logic [2:0] ic_cnt, grp_cnt, give;
    logic [1:0] unresolved;
    logic [3:0] lat;
    logic want_taken, pend, exp_branch_target_instruction_cache;
    logic [15:0] bt_v;         // Model of target cache valid bits
    logic [31:0] bt_tag [16];  // Model of target cache tags
    logic [31:0] ras [$];      // Model of the return stack
    int n_mismatch, checks_done, since, exp_gap, gaps, n_flush;
    int cycles, seed, i, g0, f0;

    always #5 clk_sys = ~clk_sys;

    bfu_core uut (.clk_sys(clk_sys), .rst(rst), .br_valid(br_valid),
        .br_kind(br_kind), .br_pc(br_pc), .br_target(br_target),
        .br_pred_taken(br_pred_taken), .br_sets_link(br_sets_link),
        .cond_known(cond_known), .cond_taken(cond_taken),
        .link_ready(link_ready), .link_value(link_value),
        .count_ready(count_ready), .count_value(count_value),
        .count_zero(count_zero), .ic_req(ic_req), .ic_addr(ic_addr),
        .ic_cnt(ic_cnt), .grp_valid(grp_valid), .grp_addr(grp_addr),
        .grp_cnt(grp_cnt), .grp_branch_target_instruction_cache(grp_branch_target_instruction_cache), .br_done(br_done),
        .br_fold(br_fold), .flush(flush), .unresolved(unresolved));

    bfu_far_model far (.clk_sys(clk_sys), .rst(rst),
        .unresolved(unresolved), .give(give), .lat(lat),
        .want_taken(want_taken), .tval(tval), .cond_known(cond_known),
        .cond_taken(cond_taken), .link_ready(link_ready),
        .link_value(link_value), .count_ready(count_ready),
        .count_value(count_value), .count_zero(count_zero));

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run;
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Wait n edges, then let outputs settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Words up to the block end, at most one group
    function automatic logic [31:0] cnt_of(input logic [31:0] a);
        int w;
        w = (BLOCK_BYTES - (a % BLOCK_BYTES)) / WORD_BYTES;
        return (w > GROUP_MAX) ? GROUP_MAX : w;
    endfunction

    // One branch request, held until done; updates the fetch model
    task automatic exec_br(input bfu_kind_t k, input logic [31:0] pc,
                           input logic [31:0] tg, input logic pt, sl);
        int n;
        int ix;
        logic tk, dir, hit;
        logic [31:0] dst;
        tk = (k == BR_UNCOND) || pt;
        dir = (k == BR_UNCOND) || (k == BR_COND);
        ix = pc[5:2];
        hit = dir && bt_v[ix] && bt_tag[ix] == pc;
        dst = (k == BR_LINK) ? ras.pop_back() : tg;
        if (sl) ras.push_back(pc + 32'h4);
        // Taken branches stay three cycles apart
        repeat (2) @(negedge clk_sys);
        br_valid = 1'b1;
        br_kind = k;
        {br_pc, br_target} = {pc, tg};
        {br_pred_taken, br_sets_link} = {pt, sl};
        n = 0;
        do begin
            tick(1);
            n++;
        end while (br_done !== 1'b1 && n < 40);
        check("br_done", br_done, 1);
        check("br_fold", br_fold, tk & !sl & (k != BR_CNT_COND));
        @(negedge clk_sys);
        br_valid = 1'b0;
        if (tk) begin
            {exp_pc, pend, exp_branch_target_instruction_cache} = {dst, 1'b1, hit};
            since = 0;
            exp_gap = hit ? 1 : 2;
        end
        if (tk && dir && !hit) begin
            bt_v[ix] = 1'b1;
            bt_tag[ix] = pc;
        end
    endtask

    // Fetch monitor: every group against the model
    always @(posedge clk_sys) begin
        #1;
        if (!rst) begin
            since++;
            if (flush === 1'b1) begin
                n_flush++;
                {exp_pc, pend, exp_branch_target_instruction_cache} = {fix_pc, 1'b1, 1'b0};
                since = 0;
                exp_gap = 2;
            end else if (grp_valid === 1'b1) begin
                check("grp_addr", grp_addr, exp_pc);
                check("grp_cnt", grp_cnt, cnt_of(exp_pc));
                check("grp_branch_target_instruction_cache", grp_branch_target_instruction_cache, pend & exp_branch_target_instruction_cache);
                if (pend) check("grp_gap", since, exp_gap);
                exp_pc = exp_pc + 4 * cnt_of(exp_pc);
                pend = 1'b0;
            end else if (!pend) gaps++;
        end
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            complete_run;
        end
    end

    initial begin
        seed = 60446;
        {rst, br_valid, br_pred_taken, br_sets_link} = 4'b1000;
        br_kind = BR_UNCOND;
        {br_pc, br_target} = 64'h0;
        {give, lat, want_taken, tval, bt_v} = 0;
        {exp_pc, pend, fix_pc} = {RESET_PC, 1'b0, 32'h0};
        repeat (10) @(posedge clk_sys);
        check("grp_valid", grp_valid, 0);
        check("unresolved", unresolved, 0);
        @(negedge clk_sys);
        rst = 1'b0;
        tick(1);
        check("ic_addr", ic_addr, RESET_PC);
        check("ic_cnt", ic_cnt, 4);
        tick(4);
        // Direct taken to a block-end target and to a loop start: miss, then hits
        exec_br(BR_UNCOND, 32'h200, 32'h31C, 0, 0);
        exec_br(BR_UNCOND, 32'h200, 32'h31C, 0, 0);
        repeat (3) exec_br(BR_UNCOND, 32'h90C, 32'h900, 0, 0);
        // Call pushes, return predicted from the stack
        exec_br(BR_UNCOND, 32'h400, 32'h500, 0, 1);
        {give, want_taken, tval} = {3'b001, 1'b1, 32'h404};
        f0 = n_flush;
        exec_br(BR_LINK, 32'h520, 32'h0, 1, 0);
        tick(5);
        check("unresolved", unresolved, 1);
        give = 3'b011;
        tick(4);
        check("unresolved", unresolved, 0);
        check("flushes", n_flush, f0);
        give = 3'b000;
        exec_br(BR_UNCOND, 32'h520, 32'h600, 0, 0);
        // Three open conditionals hold back a fourth
        tick(4);
        g0 = gaps;
        for (i = 0; i < 3; i++) exec_br(BR_COND, 32'h640 + 8 * i, 32'hA00, 0, 0);
        check("unresolved", unresolved, 3);
        fork
            exec_br(BR_COND, 32'h660, 32'hA00, 0, 0);
            begin
                tick(6);
                check("br_done", br_done, 0);
                {give, want_taken} = {3'b001, 1'b0};
            end
        join
        tick(6);
        check("gaps", gaps - g0, 0);
        check("unresolved", unresolved, 0);
        // Slow answers that reverse each prediction
        {lat, want_taken, fix_pc} = {4'h3, 1'b1, 32'hA80};
        exec_br(BR_COND, 32'h700, 32'hA80, 0, 0);
        tick(8);
        {want_taken, fix_pc} = {1'b0, 32'h7A4};
        exec_br(BR_COND, 32'h7A0, 32'hB40, 1, 0);
        tick(8);
        check("flushes", n_flush, f0 + 2);
        check("unresolved", unresolved, 0);
        // Count register kinds
        {lat, want_taken, tval} = {4'h0, 1'b1, 32'hB80};
        exec_br(BR_COUNT, 32'h840, 32'hB80, 1, 0);
        tick(5);
        check("unresolved", unresolved, 1);
        give = 3'b101;
        tick(4);
        check("unresolved", unresolved, 0);
        give = 3'b001;
        exec_br(BR_CNT_COND, 32'h8C0, 32'hBC0, 0, 0);
        tick(5);
        check("unresolved", unresolved, 1);
        want_taken = 1'b0;
        tick(4);
        check("unresolved", unresolved, 0);
        check("flushes", n_flush, f0 + 2);
        give = 3'b000;
        // Random direct branches, repeats give target cache hits
        for (i = 0; i < 12; i++) begin
            r = $random(seed);
            exec_br(BR_UNCOND, 32'h1000 | (r & 32'h1C),
                    32'h3000 | ((r >> 8) & 32'hFFC), 0, r[0]);
        end
        tick(4);
        complete_run;
    end
endmodule
`default_nettype wire
